// *** design/pacc_pkg.sv ***
// package: register map, field positions and constants of the pulse accumulator block
package pacc_pkg;
	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CH4    = 8'h98;
	localparam logic [7:0] IDX_CH5    = 8'h9a;
	localparam logic [7:0] IDX_CH6    = 8'h9c;
	localparam logic [7:0] IDX_CH7    = 8'h9e;
	localparam logic [7:0] IDX_CTRL   = 8'ha0;
	localparam logic [7:0] IDX_FLAGS  = 8'ha1;
	localparam logic [7:0] IDX_COUNT  = 8'ha2;
	localparam logic [7:0] IDX_TEST   = 8'ha4;
	localparam logic [7:0] IDX_PORT   = 8'hae;
	localparam int         IDX_LSB    = 2;
	localparam int         IDX_MSB    = 9;
	// accumulator control fields
	localparam int CTL_ENABLE  = 6;
	localparam int CTL_MODE    = 5;
	localparam int CTL_EDGE    = 4;
	localparam int CTL_CLK_HI  = 3;
	localparam int CTL_CLK_LO  = 2;
	localparam int CTL_OVF_IE  = 1;
	localparam int CTL_IN_IE   = 0;
	// flag fields
	localparam int FLG_OVF     = 1;
	localparam int FLG_IN      = 0;
	// test fields
	localparam int TST_TIMER_BYP = 1;
	localparam int TST_ACC_BYP   = 0;
	// clock select codes
	localparam logic [1:0] CSEL_PRESCALER = 2'h0;
	localparam logic [1:0] CSEL_ACC       = 2'h1;
	localparam logic [1:0] CSEL_ACC_256   = 2'h2;
	localparam logic [1:0] CSEL_ACC_64K   = 2'h3;
	// reset values and constants
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [15:0] RST_WORD  = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [7:0]  HALF_MAX  = 8'hff;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam int          NUM_CH    = 4;
	localparam int          PORT_W    = 8;
endpackage

// *** design/timer_pulse_accumulator.sv ***
// timer_pulse_accumulator: upper capture/compare channels, pulse accumulator, port latch
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module timer_pulse_accumulator
	import pacc_pkg::*;
(
	input  wire logic                i_clk,
	input  wire logic                i_srst,
	// axi4-lite slave
	input  wire logic [31:0]         s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [31:0]         s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// timer core context
	input  wire logic                i_timer_enable_bit,
	input  wire logic                i_fast_flag_clear,
	input  wire logic                i_special_mode_low,
	input  wire logic [NUM_CH-1:0]   i_channel_function_select,
	input  wire logic [15:0]         i_free_count,
	input  wire logic                i_counter_step,
	input  wire logic [NUM_CH-1:0]   i_capture_edge,
	input  wire logic                i_prescaler_tick,
	input  wire logic                i_e_div64_tick,
	// pins
	input  wire logic                i_accumulator_input_pin,
	input  wire logic [PORT_W-1:0]   i_port_pin_level,
	input  wire logic [PORT_W-1:0]   i_port_dir,
	input  wire logic [PORT_W-1:0]   i_timer_output_pins,
	input  wire logic [PORT_W-1:0]   i_timer_output_level,
	output logic [PORT_W-1:0]        o_port_pin_out,
	// results
	output logic                     o_timer_clock_tick,
	output logic                     o_timer_chain_bypass,
	output logic [NUM_CH-1:0]        o_compare_match,
	output logic                     o_overflow_irq,
	output logic                     o_input_irq
);

	// index decode shared by the read and write paths
	function automatic logic idx_mapped(input logic [7:0] idx);
		idx_mapped = (idx == IDX_CH4) || (idx == IDX_CH5) || (idx == IDX_CH6) ||
			(idx == IDX_CH7) || (idx == IDX_CTRL) || (idx == IDX_FLAGS) ||
			(idx == IDX_COUNT) || (idx == IDX_TEST) || (idx == IDX_PORT);
	endfunction

	function automatic logic [7:0] ch_idx(input int ch);
		ch_idx = IDX_CH4 + 8'(2 * ch);
	endfunction

	logic [15:0]       chan_ff [NUM_CH];
	logic [7:0]        ctrl_ff;
	logic [7:0]        flags_ff;
	logic [15:0]       count_ff;
	logic [7:0]        test_ff;
	logic [PORT_W-1:0] port_latch_ff;
	logic              aw_got_ff;
	logic              w_got_ff;
	logic [7:0]        aw_idx_ff;
	logic [15:0]       w_data_ff;
	logic [1:0]        w_strb_ff;
	logic              sync1_ff;
	logic              sync2_ff;
	logic              pin_prev_ff;
	logic              wr_go;
	logic              rd_go;
	logic              nxt_aw_got;
	logic              nxt_w_got;
	logic              nxt_bvalid;
	logic              nxt_rvalid;
	logic              acc_on;
	logic              rise;
	logic              fall;
	logic              counted_edge;
	logic              trailing_edge;
	logic              gate_open;
	logic              gate_tick;
	logic              acc_tick;
	logic              low_wrap;
	logic              full_wrap;
	logic              count_access;
	logic [15:0]       nxt_count;
	logic [15:0]       wr_word;
	logic [31:0]       nxt_rdata;

	// bus handshakes: address and data may arrive in either order
	assign wr_go      = aw_got_ff && w_got_ff && !s_axi_bvalid;
	assign rd_go      = s_axi_arvalid && s_axi_arready;
	assign nxt_aw_got = wr_go ? 1'b0 : (aw_got_ff || (s_axi_awvalid && s_axi_awready));
	assign nxt_w_got  = wr_go ? 1'b0 : (w_got_ff || (s_axi_wvalid && s_axi_wready));
	assign nxt_bvalid = wr_go || (s_axi_bvalid && !s_axi_bready);
	assign nxt_rvalid = rd_go || (s_axi_rvalid && !s_axi_rready);

	// write-side capture and response
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			aw_idx_ff     <= RST_BYTE;
			w_data_ff     <= RST_WORD;
			w_strb_ff     <= 2'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			aw_got_ff     <= nxt_aw_got;
			w_got_ff      <= nxt_w_got;
			s_axi_awready <= !nxt_aw_got && !nxt_bvalid;
			s_axi_wready  <= !nxt_w_got && !nxt_bvalid;
			s_axi_bvalid  <= nxt_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_ff <= s_axi_awaddr[IDX_MSB:IDX_LSB];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_ff <= s_axi_wdata[15:0];
				w_strb_ff <= s_axi_wstrb[1:0];
			end
			if (wr_go) begin
				s_axi_bresp <= idx_mapped(aw_idx_ff) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// byte lanes merge with the old value so a one-byte write leaves the other byte
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	assign wr_word = merge(count_ff, w_data_ff, w_strb_ff);

	// read mux; port bits configured as inputs return the pin level
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		unique case (s_axi_araddr[IDX_MSB:IDX_LSB])
			IDX_CH4:   nxt_rdata[15:0] = chan_ff[0];
			IDX_CH5:   nxt_rdata[15:0] = chan_ff[1];
			IDX_CH6:   nxt_rdata[15:0] = chan_ff[2];
			IDX_CH7:   nxt_rdata[15:0] = chan_ff[3];
			IDX_CTRL:  nxt_rdata[7:0]  = ctrl_ff;
			IDX_FLAGS: nxt_rdata[7:0]  = flags_ff;
			IDX_COUNT: nxt_rdata[15:0] = count_ff;
			IDX_TEST:  nxt_rdata[7:0]  = test_ff;
			IDX_PORT:  nxt_rdata[7:0]  = (port_latch_ff & i_port_dir) |
				(i_port_pin_level & ~i_port_dir);
			default:   nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read channel: one answer per address, data registered
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_rvalid  <= nxt_rvalid;
			s_axi_arready <= !nxt_rvalid;
			if (rd_go) begin
				s_axi_rdata <= nxt_rdata;
				s_axi_rresp <= idx_mapped(s_axi_araddr[IDX_MSB:IDX_LSB]) ?
					RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// capture/compare channels
	for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				chan_ff[g]         <= RST_WORD;
				o_compare_match[g] <= 1'b0;
			end else begin
				if (!i_channel_function_select[g]) begin
					if (i_capture_edge[g]) begin
						chan_ff[g] <= i_free_count;
					end
				end else if (wr_go && aw_idx_ff == ch_idx(g)) begin
					chan_ff[g] <= merge(chan_ff[g], w_data_ff, w_strb_ff);
				end
				o_compare_match[g] <= i_channel_function_select[g] && i_timer_enable_bit &&
					i_counter_step && (i_free_count == chan_ff[g]);
			end
		end
	end

	// control register and the test register, which only special mode may write
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_ff <= RST_BYTE;
			test_ff <= RST_BYTE;
		end else begin
			if (wr_go && aw_idx_ff == IDX_CTRL && w_strb_ff[0]) begin
				ctrl_ff <= w_data_ff[7:0];
			end
			if (wr_go && aw_idx_ff == IDX_TEST && w_strb_ff[0] && !i_special_mode_low) begin
				test_ff <= w_data_ff[7:0];
			end
		end
	end

	// two-flop synchroniser; the pulse width limit follows from it
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sync1_ff    <= 1'b0;
			sync2_ff    <= 1'b0;
			pin_prev_ff <= 1'b0;
		end else begin
			sync1_ff    <= i_accumulator_input_pin;
			sync2_ff    <= sync1_ff;
			pin_prev_ff <= sync2_ff;
		end
	end

	// edge and gate decode
	assign acc_on        = ctrl_ff[CTL_ENABLE];
	assign rise          = sync2_ff && !pin_prev_ff;
	assign fall          = !sync2_ff && pin_prev_ff;
	assign counted_edge  = ctrl_ff[CTL_EDGE] ? rise : fall;
	// gate is high-active with edge 0, low-active with edge 1, so the trailing
	// edge is the same edge the event mode would count
	assign trailing_edge = counted_edge;
	assign gate_open     = ctrl_ff[CTL_EDGE] ? !sync2_ff : sync2_ff;
	// bypass replaces the divided clock by the module clock itself
	assign gate_tick     = i_timer_enable_bit && gate_open &&
		(test_ff[TST_ACC_BYP] || i_e_div64_tick);
	assign acc_tick      = acc_on && (ctrl_ff[CTL_MODE] ? gate_tick : counted_edge);
	assign low_wrap      = acc_tick && count_ff[7:0] == HALF_MAX;
	assign full_wrap     = acc_tick && count_ff == COUNT_MAX && !test_ff[TST_ACC_BYP];
	assign count_access  = (wr_go && aw_idx_ff == IDX_COUNT) ||
		(rd_go && s_axi_araddr[IDX_MSB:IDX_LSB] == IDX_COUNT);

	// count next value; in bypass both halves step on the same tick
	always_comb begin
		nxt_count = count_ff;
		if (acc_tick) begin
			if (test_ff[TST_ACC_BYP]) begin
				nxt_count = {count_ff[15:8] + 8'h01, count_ff[7:0] + 8'h01};
			end else begin
				nxt_count = count_ff + 16'h0001;
			end
		end
	end

	// accumulator count; a software word write wins over a same-cycle step
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			count_ff <= RST_WORD;
		end else if (wr_go && aw_idx_ff == IDX_COUNT) begin
			count_ff <= wr_word;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// flags: hardware set wins over write-one and fast clear
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			flags_ff <= RST_BYTE;
		end else begin
			if (count_access && i_fast_flag_clear) begin
				flags_ff <= RST_BYTE;
			end else if (wr_go && aw_idx_ff == IDX_FLAGS && w_strb_ff[0]) begin
				flags_ff[FLG_OVF] <= flags_ff[FLG_OVF] && !w_data_ff[FLG_OVF];
				flags_ff[FLG_IN]  <= flags_ff[FLG_IN] && !w_data_ff[FLG_IN];
			end
			if (full_wrap) begin
				flags_ff[FLG_OVF] <= 1'b1;
			end
			if (acc_on && trailing_edge) begin
				flags_ff[FLG_IN] <= 1'b1;
			end
		end
	end

	// interrupt requests follow flags and enables
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_overflow_irq <= 1'b0;
			o_input_irq    <= 1'b0;
		end else begin
			o_overflow_irq <= flags_ff[FLG_OVF] && ctrl_ff[CTL_OVF_IE];
			o_input_irq    <= flags_ff[FLG_IN] && ctrl_ff[CTL_IN_IE];
		end
	end

	// timer counter clock select; disabled accumulator falls back to prescaler
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_timer_clock_tick   <= 1'b0;
			o_timer_chain_bypass <= 1'b0;
		end else begin
			o_timer_chain_bypass <= test_ff[TST_TIMER_BYP];
			if (!i_timer_enable_bit) begin
				o_timer_clock_tick <= 1'b0;
			end else if (!acc_on) begin
				o_timer_clock_tick <= test_ff[TST_TIMER_BYP] || i_prescaler_tick;
			end else begin
				unique case ({ctrl_ff[CTL_CLK_HI], ctrl_ff[CTL_CLK_LO]})
					CSEL_PRESCALER: o_timer_clock_tick <= test_ff[TST_TIMER_BYP] ||
						i_prescaler_tick;
					CSEL_ACC:       o_timer_clock_tick <= acc_tick;
					CSEL_ACC_256:   o_timer_clock_tick <= low_wrap;
					CSEL_ACC_64K:   o_timer_clock_tick <= acc_tick && count_ff == COUNT_MAX;
				endcase
			end
		end
	end

	// port latch; pins owned by a timer output ignore the latch
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			port_latch_ff  <= RST_BYTE;
			o_port_pin_out <= RST_BYTE;
		end else begin
			if (wr_go && aw_idx_ff == IDX_PORT && w_strb_ff[0]) begin
				port_latch_ff <= w_data_ff[7:0];
			end
			o_port_pin_out <= (i_timer_output_pins & i_timer_output_level) |
				(~i_timer_output_pins & port_latch_ff);
		end
	end

endmodule

// *** sim/pacc_pulse_source.sv ***
// partner: pulse source on the accumulator input pin
`timescale 1ns/10ps
module pacc_pulse_source (
	input  wire logic	i_clk,
	output logic		o_pin
);
	// pin idles low between pulses
	initial o_pin = 1'b0;
	// pulse of w clocks at lvl, then w clocks back; w above two clocks for the synchroniser
	task pulse(input logic lvl, input int w);
		@(posedge i_clk) o_pin <= lvl;
		repeat (w) @(posedge i_clk);
		o_pin <= ~lvl;
		repeat (w) @(posedge i_clk);
	endtask
	// hold a gate level until told otherwise
	task drive(input logic lvl);
		@(posedge i_clk) o_pin <= lvl;
	endtask
endmodule

// *** sim/timer_pulse_accumulator_monitor.sv ***
// checker: port-level assertions on the pulse accumulator block
`timescale 1ns/10ps
module timer_pulse_accumulator_monitor
	import pacc_pkg::*;
(
	input wire logic		i_clk,
	input wire logic		i_srst,
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready,
	input wire logic		s_axi_bvalid,
	input wire logic		s_axi_arvalid,
	input wire logic		s_axi_arready,
	input wire logic		s_axi_rvalid,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic		i_timer_enable_bit,
	input wire logic		i_special_mode_low,
	input wire logic [3:0]	i_channel_function_select,
	input wire logic		i_accumulator_input_pin,
	input wire logic		o_timer_clock_tick,
	input wire logic		o_timer_chain_bypass,
	input wire logic [3:0]	o_compare_match,
	input wire logic		o_overflow_irq,
	input wire logic		o_input_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);
	// bus answers come on the promised edge and block new requests meanwhile
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("late write response");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during response");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& !s_axi_arready) else $error("late read response");
	rd_error_a: assert property (s_axi_rvalid && s_axi_rresp != RESP_OKAY |-> s_axi_rresp
		== RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("bad error read");
	// no counter clock without the timer enable
	tick_gate_a: assert property (!i_timer_enable_bit |=> !o_timer_clock_tick)
		else $error("tick while timer off");
	// only output-compare channels may match
	match_mode_a: assert property (|o_compare_match
		|-> (o_compare_match & ~$past(i_channel_function_select)) == 4'h0) else $error("bad match");
	// test bit moves only through a write in special mode
	// the test bit lands at the response edge and shows on the port one edge later
	bypass_write_a: assert property ($changed(o_timer_chain_bypass)
		|-> $past(s_axi_bvalid) && !$past(i_special_mode_low, 2)) else $error("test bit changed");
	// input request rises after a pin edge has crossed the synchroniser, or a write
	in_irq_cause_a: assert property ($rose(o_input_irq) |-> s_axi_bvalid
		|| $past(s_axi_bvalid) || $past(i_accumulator_input_pin, 3)
		!= $past(i_accumulator_input_pin, 5)) else $error("input request without cause");
	cover property (o_overflow_irq);
	cover property (o_timer_chain_bypass && o_timer_clock_tick);
	cover property (|o_compare_match);
endmodule
bind timer_pulse_accumulator timer_pulse_accumulator_monitor timer_pulse_accumulator_monitor_inst (
	.i_clk, .i_srst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp,
	.s_axi_rdata, .i_timer_enable_bit, .i_special_mode_low, .i_channel_function_select,
	.i_accumulator_input_pin, .o_timer_clock_tick, .o_timer_chain_bypass,
	.o_compare_match, .o_overflow_irq, .o_input_irq);

// *** sim/timer_pulse_accumulator_tb.sv ***
// testbench: register bus scenarios for the pulse accumulator block
`timescale 1ns/10ps
module timer_pulse_accumulator_tb import pacc_pkg::*;;
	logic			i_clk, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic			i_srst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic			s_axi_bready = 1'b1, s_axi_rready = 1'b1, i_timer_enable_bit = 1'b0;
	logic			i_fast_flag_clear = 1'b0, i_special_mode_low = 1'b1, i_counter_step = 1'b0;
	logic			i_prescaler_tick = 1'b0, i_e_div64_tick = 1'b0, i_accumulator_input_pin;
	logic			o_timer_clock_tick, o_timer_chain_bypass, o_overflow_irq, o_input_irq;
	logic [1:0]		s_axi_bresp, s_axi_rresp;
	logic [3:0]		s_axi_wstrb = 4'hf, i_capture_edge = 4'h0, o_compare_match;
	logic [3:0]		i_channel_function_select = 4'h1;
	logic [15:0]	i_free_count = 16'h0000;
	logic [31:0]	s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [7:0]		i_port_pin_level = 8'h00, i_port_dir = 8'hff, i_timer_output_pins = 8'h0f;
	logic [7:0]		i_timer_output_level = 8'h0a, o_port_pin_out;
	int				bad_count = 0, samples_checked = 0, cyc = 0;

	timer_pulse_accumulator timer_pulse_accumulator_inst (.i_clk, .i_srst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .i_timer_enable_bit,
		.i_fast_flag_clear, .i_special_mode_low, .i_channel_function_select, .i_free_count,
		.i_counter_step, .i_capture_edge, .i_prescaler_tick, .i_e_div64_tick,
		.i_accumulator_input_pin, .i_port_pin_level, .i_port_dir, .i_timer_output_pins,
		.i_timer_output_level, .o_port_pin_out, .o_timer_clock_tick, .o_timer_chain_bypass,
		.o_compare_match, .o_overflow_irq, .o_input_irq);
	pacc_pulse_source pacc_pulse_source_inst (.i_clk, .o_pin(i_accumulator_input_pin));

	// 50 ns clock
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// hang guard, far above the few hundred cycles the scenarios need
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bus master: valid held until its ready edge, wait for the answer with no assumed latency
	task wr(input logic [7:0] idx, input logic [31:0] d);
		@(posedge i_clk);
		s_axi_awaddr <= {22'h0, idx, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge i_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk({30'h0, s_axi_bresp}, 32'h0);
	endtask
	task rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		@(posedge i_clk);
		s_axi_araddr <= {22'h0, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge i_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		chk(s_axi_rdata, exp);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	// counts timer ticks over eight cycles, prescaler held at lvl for six
	task tcount(input logic lvl, input logic [31:0] exp);
		logic [31:0] k;
		k = 0;
		@(posedge i_clk) i_prescaler_tick <= lvl;
		for (int j = 0; j < 8; j++) begin
			@(posedge i_clk);
			k = k + o_timer_clock_tick;
			if (j == 5) i_prescaler_tick <= 1'b0;
		end
		chk(k, exp);
	endtask
	task t_channels();
		logic [3:0] m;
		m = 4'h0;
		rd(8'h80, 32'h0, RESP_SLVERR);
		wr(IDX_CH4, 32'h0000_1234);
		wr(IDX_CH5, 32'h0000_5678);
		rd(IDX_CH4, 32'h0000_1234, RESP_OKAY);
		rd(IDX_CH5, 32'h0000_0000, RESP_OKAY);
		@(posedge i_clk);
		i_free_count <= 16'h1234;
		i_timer_enable_bit <= 1'b1;
		i_counter_step <= 1'b1;
		i_capture_edge <= 4'h2;
		@(posedge i_clk);
		i_counter_step <= 1'b0;
		i_capture_edge <= 4'h0;
		repeat (3) begin
			@(posedge i_clk);
			m = m | o_compare_match;
		end
		chk({28'h0, m}, 32'h1);
		rd(IDX_CH5, 32'h0000_1234, RESP_OKAY);
	endtask
	task t_event();
		wr(IDX_CTRL, 32'h51);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		rd(IDX_COUNT, 32'h2, RESP_OKAY);
		chk(o_input_irq, 1'b1);
		wr(IDX_CTRL, 32'h50);
		repeat (3) @(posedge i_clk);
		chk(o_input_irq, 1'b0);
		wr(IDX_FLAGS, 32'h1);
		wr(IDX_CTRL, 32'h11);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		rd(IDX_COUNT, 32'h2, RESP_OKAY);
		chk(o_input_irq, 1'b0);
		wr(IDX_CTRL, 32'h40);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		rd(IDX_COUNT, 32'h3, RESP_OKAY);
	endtask
	task t_overflow();
		wr(IDX_COUNT, 32'hffff);
		wr(IDX_CTRL, 32'h42);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		rd(IDX_COUNT, 32'h0, RESP_OKAY);
		chk(o_overflow_irq, 1'b1);
		wr(IDX_FLAGS, 32'h2);
		repeat (3) @(posedge i_clk);
		chk(o_overflow_irq, 1'b0);
		wr(IDX_COUNT, 32'hffff);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		// flag lands on the last pulse edge, the request one edge later
		repeat (2) @(posedge i_clk);
		chk(o_overflow_irq, 1'b1);
		@(posedge i_clk) i_fast_flag_clear <= 1'b1;
		rd(IDX_COUNT, 32'h0, RESP_OKAY);
		repeat (3) @(posedge i_clk);
		chk(o_overflow_irq, 1'b0);
		i_fast_flag_clear <= 1'b0;
	endtask
	// gated mode: e/64 ticks counted only while the gate is open and the timer runs
	task t_gated(input logic timer_enable_bit, input logic [31:0] exp);
		@(posedge i_clk) i_timer_enable_bit <= timer_enable_bit;
		pacc_pulse_source_inst.drive(1'b1);
		repeat (4) @(posedge i_clk);
		i_e_div64_tick <= 1'b1;
		repeat (5) @(posedge i_clk);
		i_e_div64_tick <= 1'b0;
		pacc_pulse_source_inst.drive(1'b0);
		repeat (5) @(posedge i_clk);
		rd(IDX_COUNT, exp, RESP_OKAY);
		chk(o_input_irq, 1'b1);
		wr(IDX_FLAGS, 32'h3);
	endtask
	task t_clock();
		// the gated test left the timer off; the select paths need it running
		@(posedge i_clk) i_timer_enable_bit <= 1'b1;
		wr(IDX_CTRL, 32'h04);
		tcount(1'b1, 32'h6);
		wr(IDX_CTRL, 32'h44);
		tcount(1'b1, 32'h0);
		wr(IDX_CTRL, 32'h00);
		@(posedge i_clk) i_timer_enable_bit <= 1'b0;
		tcount(1'b1, 32'h0);
		@(posedge i_clk) i_timer_enable_bit <= 1'b1;
		wr(IDX_TEST, 32'h2);
		rd(IDX_TEST, 32'h0, RESP_OKAY);
		@(posedge i_clk) i_special_mode_low <= 1'b0;
		wr(IDX_TEST, 32'h2);
		rd(IDX_TEST, 32'h2, RESP_OKAY);
		chk(o_timer_chain_bypass, 1'b1);
		tcount(1'b0, 32'h8);
		wr(IDX_TEST, 32'h0);
	endtask
	task t_port();
		wr(IDX_PORT, 32'ha5);
		repeat (3) @(posedge i_clk);
		chk(o_port_pin_out, 32'haa);
	endtask
	// one falling-edge event from a preset count; timer ticks counted alongside
	task t_select(input logic [31:0] ctl, input logic [31:0] cnt, input logic [31:0] exp);
		logic [31:0] k;
		k = 0;
		wr(IDX_COUNT, cnt);
		wr(IDX_CTRL, ctl);
		fork
			pacc_pulse_source_inst.pulse(1'b1, 3);
			repeat (9) begin
				@(posedge i_clk);
				k = k + o_timer_clock_tick;
			end
		join
		chk(k, exp);
	endtask
	// accumulator bypass: halves step together, no 16-bit overflow flag
	task t_bypass();
		wr(IDX_TEST, 32'h1);
		wr(IDX_FLAGS, 32'h3);
		wr(IDX_COUNT, 32'h00fe);
		wr(IDX_CTRL, 32'h42);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		rd(IDX_COUNT, 32'h01ff, RESP_OKAY);
		wr(IDX_COUNT, 32'hffff);
		pacc_pulse_source_inst.pulse(1'b1, 3);
		rd(IDX_COUNT, 32'h0, RESP_OKAY);
		chk(o_overflow_irq, 1'b0);
		wr(IDX_TEST, 32'h0);
	endtask
	task end_sim();
		$display("comparisons %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// reset for two cycles, then the scenarios in turn
	initial begin
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		rd(IDX_COUNT, 32'h0, RESP_OKAY);
		t_channels();
		t_event();
		t_overflow();
		wr(IDX_COUNT, 32'h0);
		wr(IDX_CTRL, 32'h61);
		t_gated(1'b1, 32'h5);
		t_gated(1'b0, 32'h5);
		t_clock();
		t_select(32'h44, 32'h0000, 32'h1);
		t_select(32'h48, 32'h00fe, 32'h0);
		t_select(32'h48, 32'h00ff, 32'h1);
		t_select(32'h4c, 32'h00ff, 32'h0);
		t_select(32'h4c, 32'hffff, 32'h1);
		t_bypass();
		t_port();
		end_sim();
	end
endmodule
